// [include/line_port_defs.vh]
// offsets, field positions, reset values and timing counts for line port pin control
// What this block does
// - writing a one to an async port bit drives its pin, bits 0-3 the tx data pins, bits 4-7 the rts pins.
// - reading the async port register returns live pins, bits 0-3 rx data, bits 4-7 cts.
// - each async port bit is usable only while its channel is in asynchronous mode.
// - channels 3, 2 and 1 are reachable only while their select bit in the pin group register is set.
// - bit 2 of a line clock control register makes the clock pin an input when clear and an output when set.
// - the two-bit rate field picks 2.048, 4.096, 8.192 or 16.384 MHz.
// - the rate only matters while the clock pin is an output, otherwise the outside sets the clock.
// - after reset every clock pin is an input with the 2.048 MHz rate code.
// - unused bits of the line clock control registers read as zero.
// - select bit 0 gives the backplane pins to channel 1 when set, to the backplane when clear.
// - select bit 1 gives pcm ports 0 and 2 pins to channel 2 when set, to pcm when clear.
// - select bit 2 gives pcm ports 1 and 3 pins to channel 3 when set, to pcm when clear.
`ifndef LINE_PORT_DEFS_VH
`define LINE_PORT_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LCLK_CTRL0_IDX   16'hD08A
`define LCLK_CTRL1_IDX   16'hD08B
`define LCLK_CTRL2_IDX   16'hD08C
`define LCLK_CTRL3_IDX   16'hD08D
`define ASYNC_PORT_IDX   16'hD0D2
`define PIN_GROUP_IDX    16'hD14A
`define ASYNC_MODE_IDX   16'hD0F0

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LCLK_RATE_LSB    0
`define LCLK_OE_BIT      2
`define LCLK_CTRL_W      3
`define LCLK_CTRL_RST    3'h0
`define PIN_GROUP_W      3
`define PIN_GROUP_RST    3'h0
`define ASYNC_PORT_RST   8'h00
`define ASYNC_MODE_RST   4'h0

// ----------------------------------------------------------------
// clock rates in kHz and the system clock
// ----------------------------------------------------------------
`define SYS_CLK_KHZ      100000
`define RATE0_KHZ        17'd2048
`define RATE1_KHZ        17'd4096
`define RATE2_KHZ        17'd8192
`define RATE3_KHZ        17'd16384
`define ACC_W            18
`define ACC_MOD          18'd100000

`endif

// [src/line_clock_gen.v]
// one line clock generator: phase accumulator giving the selected rate
`timescale 1ns/100ps
`include "line_port_defs.vh"
module line_clock_gen #(
    parameter ACC_W = `ACC_W
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       out_en_i,
    input  wire [1:0] rate_i,
    // clock pin
    output reg        line_clock_o,
    output wire       line_clock_oe_o
);
    // ----------------------------------------------------------------
    // fractional divider
    // ----------------------------------------------------------------
    // a half period equals 2*rate kHz out of 100 MHz; jitter of one clk is
    // the price of exact average frequency without a pll
    function [ACC_W-1:0] step_of;
        input [1:0] r;
        begin
            case (r)
                2'h0:    step_of = {`RATE0_KHZ, 1'b0};
                2'h1:    step_of = {`RATE1_KHZ, 1'b0};
                2'h2:    step_of = {`RATE2_KHZ, 1'b0};
                default: step_of = {`RATE3_KHZ, 1'b0};
            endcase
        end
    endfunction

    reg  [ACC_W-1:0] acc_r;
    wire [ACC_W:0]   sum = {1'b0, acc_r} + {1'b0, step_of(rate_i)};

    assign line_clock_oe_o = out_en_i;

    always @(posedge clk_i) begin
        if (rst_i || !out_en_i) begin
            acc_r        <= {ACC_W{1'b0}};
            line_clock_o <= 1'b0;
        end else if (sum >= {1'b0, `ACC_MOD}) begin
            acc_r        <= sum[ACC_W-1:0] - `ACC_MOD;
            line_clock_o <= ~line_clock_o;
        end else begin
            acc_r        <= sum[ACC_W-1:0];
        end
    end
endmodule // line_clock_gen

// [src/line_port_pin_control.v]
// line port pin control: async port, line clock pins and pin group select
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`include "line_port_defs.vh"
module line_port_pin_control #(
    parameter NCH = 4
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [17:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // async pins
    output wire [3:0]  line_tx_data_o,
    output wire [3:0]  line_tx_data_oe_o,
    output wire [3:0]  line_request_to_send_o,
    output wire [3:0]  line_request_to_send_oe_o,
    input  wire [3:0]  line_rx_data_i,
    input  wire [3:0]  line_clear_to_send_i,
    // line clock pins
    output wire [3:0]  line_clock_o,
    output wire [3:0]  line_clock_oe_o,
    // pin group steering
    output wire        backplane_pins_to_channel1_o,
    output wire        pcm02_pins_to_channel2_o,
    output wire        pcm13_pins_to_channel3_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [`LCLK_CTRL_W-1:0] lclk_ctrl_r [0:3];
    reg [7:0]              port_pin_bits_r;
    reg [`PIN_GROUP_W-1:0] pin_group_r;
    reg [3:0]              async_mode_r;

    // channel usable in async mode: channels 1..3 also need their pin group
    wire [3:0] reach = {pin_group_r[2], pin_group_r[1], pin_group_r[0], 1'b1};
    wire [3:0] usable = async_mode_r & reach;
    wire [7:0] bit_ok = {usable, usable};

    wire [15:0] idx    = adr_i[17:2];
    wire        req    = cyc_i && stb_i && !ack_o;
    // a write lands at the edge where the master sees ack, never earlier
    wire        wr     = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    wire        is_clk = (idx >= `LCLK_CTRL0_IDX) && (idx <= `LCLK_CTRL3_IDX);
    wire [1:0]  clk_n  = idx[1:0] - 2'h2;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < 4; i = i + 1)
                lclk_ctrl_r[i] <= `LCLK_CTRL_RST;
            port_pin_bits_r <= `ASYNC_PORT_RST;
            pin_group_r     <= `PIN_GROUP_RST;
            async_mode_r    <= `ASYNC_MODE_RST;
        end else if (wr) begin
            if (is_clk)
                lclk_ctrl_r[clk_n] <= dat_i[`LCLK_CTRL_W-1:0];
            if (idx == `ASYNC_PORT_IDX)
                port_pin_bits_r <= (dat_i[7:0] & bit_ok) | (port_pin_bits_r & ~bit_ok);
            if (idx == `PIN_GROUP_IDX)
                pin_group_r <= dat_i[`PIN_GROUP_W-1:0];
            if (idx == `ASYNC_MODE_IDX)
                async_mode_r <= dat_i[3:0];
        end
    end

    // ----------------------------------------------------------------
    // bus answer: registered ack one cycle after the request, unmapped reads return zero
    // ----------------------------------------------------------------
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (is_clk)
            rd_nxt = {29'h0, lclk_ctrl_r[clk_n]};
        else if (idx == `ASYNC_PORT_IDX)
            rd_nxt = {24'h0, {line_clear_to_send_i, line_rx_data_i} & bit_ok};
        else if (idx == `PIN_GROUP_IDX)
            rd_nxt = {29'h0, pin_group_r};
        else if (idx == `ASYNC_MODE_IDX)
            rd_nxt = {28'h0, async_mode_r};
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_nxt : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // pins of a channel out of async mode are released so the framer may own them
    assign line_tx_data_o            = port_pin_bits_r[3:0];
    assign line_request_to_send_o    = port_pin_bits_r[7:4];
    assign line_tx_data_oe_o         = usable;
    assign line_request_to_send_oe_o = usable;

    assign backplane_pins_to_channel1_o = pin_group_r[0];
    assign pcm02_pins_to_channel2_o     = pin_group_r[1];
    assign pcm13_pins_to_channel3_o     = pin_group_r[2];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_clk
            line_clock_gen u_gen (
                .clk_i           (clk_i),
                .rst_i           (rst_i),
                .out_en_i        (lclk_ctrl_r[g][`LCLK_OE_BIT]),
                .rate_i          (lclk_ctrl_r[g][1:0]),
                .line_clock_o    (line_clock_o[g]),
                .line_clock_oe_o (line_clock_oe_o[g])
            );
        end
    endgenerate
endmodule // line_port_pin_control

// [verif/line_equip_model.sv]
// line transceiver model driving the rx data and cts pins
`timescale 1ns/100ps
module line_equip_model (
    // level pattern from the bench
    input  wire [7:0] pat_i,
    // pins into the block
    output wire [3:0] rx_o,
    output wire [3:0] cts_o
);
    // the far end always drives these lines, so there is no released level
    assign rx_o  = pat_i[3:0];
    assign cts_o = pat_i[7:4];
endmodule // line_equip_model

// [verif/line_port_pin_control_sva.sv]
// port assertions for line port pin control
`timescale 1ns/100ps
module lppc_sva (
    // clock, reset and wishbone
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [17:0] adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // pins
    input wire [3:0]  line_tx_data_o,
    input wire [3:0]  line_request_to_send_o,
    input wire [3:0]  line_tx_data_oe_o,
    input wire [3:0]  line_clock_o,
    input wire [3:0]  line_clock_oe_o,
    input wire        backplane_pins_to_channel1_o,
    input wire        pcm02_pins_to_channel2_o,
    input wire        pcm13_pins_to_channel3_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire        wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    wire [15:0] ix = adr_i[17:2];
    property p_oe; wr && ix == 16'hD08A |=> line_clock_oe_o[0] == $past(dat_i[2]); endproperty
    a_oe: assert property (p_oe) else $error("clock enable not taken");
    property p_idle; (line_clock_o & ~line_clock_oe_o & ~$past(line_clock_oe_o)) == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("clock driven while input");
    property p_rst; $past(rst_i) |-> line_clock_oe_o == 4'h0 && !backplane_pins_to_channel1_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_bp; wr && ix == 16'hD14A |=> backplane_pins_to_channel1_o == $past(dat_i[0]);
    endproperty
    a_bp: assert property (p_bp) else $error("backplane select wrong");
    property p_pcm; wr && ix == 16'hD14A |=>
        {pcm13_pins_to_channel3_o, pcm02_pins_to_channel2_o} == $past(dat_i[2:1]); endproperty
    a_pcm: assert property (p_pcm) else $error("pcm select wrong");
    property p_reach; (line_tx_data_oe_o[3:1] & ~{pcm13_pins_to_channel3_o,
        pcm02_pins_to_channel2_o, backplane_pins_to_channel1_o}) == 3'h0; endproperty
    a_reach: assert property (p_reach) else $error("unreachable channel enabled");
    property p_hold; !(wr && ix == 16'hD0D2) |=> $stable({line_request_to_send_o, line_tx_data_o});
    endproperty
    a_hold: assert property (p_hold) else $error("port pins moved without write");
    property p_zero; ack_o && $past(!we_i && ix >= 16'hD08A && ix <= 16'hD08D) |->
        dat_o[31:3] == 29'h0; endproperty
    a_zero: assert property (p_zero) else $error("unused clock bits not zero");
endmodule // lppc_sva
bind line_port_pin_control lppc_sva u_lppc_sva (.*);

// [verif/tb_top.sv]
// self-checking bench for line port pin control
`timescale 1ns/100ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [17:0] adr_i = 0;
    logic [31:0] dat_i = 0, q;
    logic [7:0]  pat = 0;
    logic [3:0]  pv;
    wire  [31:0] dat_o;
    wire         ack_o, bp, p02, p13;
    wire  [3:0]  tx, tx_oe, rts, rts_oe, rx, cts, lc, lc_oe;
    integer      mismatches = 0, check_count = 0, i, cnt[4];
    logic [15:0] rg[7] = '{16'hD08A, 16'hD08B, 16'hD08C, 16'hD08D, 16'hD0D2, 16'hD14A, 16'h0100};
    always #5 clk_i = ~clk_i;
    line_port_pin_control u_line_port_pin_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .line_tx_data_o(tx), .line_tx_data_oe_o(tx_oe), .line_request_to_send_o(rts),
        .line_request_to_send_oe_o(rts_oe), .line_rx_data_i(rx), .line_clear_to_send_i(cts),
        .line_clock_o(lc), .line_clock_oe_o(lc_oe), .backplane_pins_to_channel1_o(bp),
        .pcm02_pins_to_channel2_o(p02), .pcm13_pins_to_channel3_o(p13));
    line_equip_model u_line_equip_model (.pat_i(pat), .rx_o(rx), .cts_o(cts));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [15:0] ix, input logic [31:0] d);
        integer n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, ix, 2'b00, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // reset values, unmapped address included
    task t_reset;
        for (i = 0; i < 7; i++) begin
            wb(0, rg[i], 0);
            chk(q, 0);
        end
    endtask
    // each clock pin out at its own rate, edges counted over 10000 cycles
    task t_clock;
        for (i = 0; i < 4; i++) wb(1, rg[i], 32'hFFFFFFFC | i);
        for (i = 0; i < 4; i++) begin
            wb(0, rg[i], 0);
            chk(q, 4 | i);
            cnt[i] = 0;
        end
        chk(lc_oe, 4'hF);
        pv = lc;
        repeat (10000) begin
            @(posedge clk_i);
            for (i = 0; i < 4; i++) cnt[i] += lc[i] & !pv[i];
            pv = lc;
        end
        for (i = 0; i < 4; i++) chk(cnt[i] >= (2048 << i) / 10 && cnt[i] <= (2048 << i) / 10 + 1, 1);
        for (i = 0; i < 4; i++) wb(1, rg[i], 0);
        chk(lc_oe, 0);
    endtask
    task t_mux;
        for (i = 0; i < 8; i++) begin
            wb(1, 16'hD14A, i);
            chk({p13, p02, bp}, i);
        end
    endtask
    task t_async;
        wb(1, 16'hD0F0, 32'hF);
        wb(1, 16'hD14A, 0);
        wb(1, 16'hD0D2, 32'hFF);
        chk({rts, tx, tx_oe}, 12'h111);
        pat <= 8'hFF;
        wb(0, 16'hD0D2, 0);
        chk(q, 32'h11);
        wb(1, 16'hD14A, 7);
        wb(1, 16'hD0D2, 32'hA5);
        chk({rts, tx}, 8'hA5);
        pat <= 8'h3C;
        wb(0, 16'hD0D2, 0);
        chk(q, 32'h3C);
        wb(1, 16'hD0F0, 0);
        wb(0, 16'hD0D2, 0);
        chk({q, tx_oe}, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        t_reset;
        t_clock;
        t_mux;
        t_async;
        test_done;
    end
    initial begin
        #1000000;
        mismatches++;
        test_done;
    end
endmodule // tb_top
